// [srs_pkg.sv]
`default_nettype none
package srs_pkg;
  localparam int REF_CLK_MHZ = 200;
  localparam int MIN_RESET_LOW_NS = 100;
  localparam int MIN_RESET_LOW_CYC = (MIN_RESET_LOW_NS * REF_CLK_MHZ + 999) / 1000;
  localparam int PIN_CNT_W = 8;
  localparam logic [PIN_CNT_W-1:0] PIN_LOW_LAST = PIN_CNT_W'(MIN_RESET_LOW_CYC - 1);
  localparam int CNT_W = 12;
  localparam int STAB_CYC = 4096;
  localparam int VEC_CYC = 64;
  localparam int STOP_REC_LONG_CYC = 4096;
  localparam int STOP_REC_SHORT_CYC = 32;
  localparam logic [CNT_W-1:0] STAB_LAST = CNT_W'(STAB_CYC - 1);
  localparam logic [CNT_W-1:0] VEC_LAST = CNT_W'(VEC_CYC - 1);
  localparam logic [CNT_W-1:0] STOP_REC_LONG_LAST = CNT_W'(STOP_REC_LONG_CYC - 1);
  localparam logic [CNT_W-1:0] STOP_REC_SHORT_LAST = CNT_W'(STOP_REC_SHORT_CYC - 1);
  localparam logic [CNT_W-1:0] CNT_ZERO = 12'h000;
  localparam logic [CNT_W-1:0] CNT_ONE = 12'h001;
  localparam logic [CNT_W-1:0] CNT_FULL = 12'hfff;
  localparam logic [CNT_W-1:0] SERVICE_KEEP = 12'h00f;
  localparam int WDOG_W = 6;
  localparam logic [WDOG_W-1:0] WDOG_ZERO = 6'h00;
  localparam logic [WDOG_W-1:0] WDOG_ONE = 6'h01;
  localparam logic [WDOG_W-1:0] WDOG_FULL = 6'h3f;
  localparam logic [15:0] ADDR_CAUSE = 16'hfe01;
  localparam logic [15:0] ADDR_CONFIG = 16'h001f;
  localparam logic [15:0] ADDR_SERVICE = 16'hffff;
  localparam logic [15:0] VEC_USER = 16'hfffe;
  localparam logic [15:0] VEC_MONITOR = 16'hfefe;
  localparam int CB_POR = 7;
  localparam int CB_PIN = 6;
  localparam int CB_WDOG = 5;
  localparam int CB_ILLEGAL_OPCODE_FLAG = 4;
  localparam int CB_ILLEGAL_ADDRESS_FLAG = 3;
  localparam int CB_MEN = 2;
  localparam int CB_LVI = 1;
  localparam logic [7:0] CAUSE_RESET = 8'h80;
  localparam logic [7:0] DATA_ZERO = 8'h00;
  localparam int CFG_STOP_EN = 0;
  localparam int CFG_SHORT_STOP_RECOVERY = 1;
  localparam int CFG_W = 2;
  localparam logic [CFG_W-1:0] CFG_RESET = 2'h0;
  localparam int SY_POR = 0;
  localparam int SY_LVI = 1;
  localparam int SY_PIN = 2;
  localparam int SY_TST = 3;
  localparam int SY_MEN = 4;
  localparam int SY_WDOG = 5;
  localparam int SY_W = 6;
  localparam logic [SY_W-1:0] SY_RESET = 6'h04;
  typedef enum logic [2:0] {
    ST_STAB,
    ST_VEC,
    ST_PIN,
    ST_RUN,
    ST_WAIT,
    ST_STOP,
    ST_STOP_REC
  } srs_state_e;
endpackage : srs_pkg
`default_nettype wire

// [srs_wdog_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface srs_wdog_if;
  logic tick;
  logic service;
  logic disable_wd;
  logic clear;
  logic overflow;
  modport ctrl (
    output tick,
    output service,
    output disable_wd,
    output clear,
    input overflow
  );
  modport wdog (
    input tick,
    input service,
    input disable_wd,
    input clear,
    output overflow
  );
endinterface : srs_wdog_if
`default_nettype wire

// [srs_wdog.sv]
`timescale 1ns/1ps
`default_nettype none
module srs_wdog (
  input wire logic ref_clk,
  input wire logic rst_n,
  srs_wdog_if.wdog wd
);
  logic [srs_pkg::WDOG_W-1:0] count_q;
  logic ovf_q;

  // overflow is held as a level so the controller can cross it safely
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n || wd.clear)
    begin
      count_q <= srs_pkg::WDOG_ZERO;
    end
    else if (wd.service)
    begin
      count_q <= srs_pkg::WDOG_ZERO;
    end
    else if (wd.tick && !wd.disable_wd)
    begin
      count_q <= count_q + srs_pkg::WDOG_ONE;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n || wd.clear)
    begin
      ovf_q <= 1'b0;
    end
    else if (wd.tick && !wd.disable_wd && !wd.service && count_q == srs_pkg::WDOG_FULL)
    begin
      ovf_q <= 1'b1;
    end
  end

  assign wd.overflow = ovf_q;
endmodule : srs_wdog
`default_nettype wire

// [srs_top.sv]
// What this block does
// - bus clock is generator output halved
// - power or low voltage: 4096 cycles clocks off
// - then 64 more cycles before cpu release
// - stop exit: count, clocks off until done
// - wait mode stops cpu clock only
// - resets assert internal reset, pick vector
// - internal reset returns registers to defaults
// - reset events clear counter, set cause flag
// - pin low halts; flag after minimum low
// - watchdog overflow captured as asynchronous
// - power-on: pulse, reset, clock on, flags
// - clock generator output enabled at power-on
// - watchdog overflow resets and sets flag
// - top byte write clears watchdog, counter stages
// - counter rollover clocks the watchdog counter
// - watchdog disabled only by test voltage, monitor
// - illegal instruction sets flag and resets
// - stop with stop disabled is illegal opcode
// - only unmapped opcode fetch resets, sets flag
// - twelve bit free running counter
// - short stop recovery uses 32 cycles
//
// Decided for this implementation: the register offsets and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module srs_top (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic power_on_pulse,
  input wire logic low_voltage_detect,
  input wire logic ext_reset_n,
  input wire logic test_high_voltage,
  input wire logic blank_vector_monitor_reset,
  input wire logic monitor_mode,
  input wire logic cpu_illegal_op,
  input wire logic cpu_opcode_fetch,
  input wire logic cpu_addr_unmapped,
  input wire logic cpu_stop_exec,
  input wire logic cpu_wait_exec,
  input wire logic wake_irq,
  input wire logic [15:0] bus_addr,
  input wire logic [7:0] bus_wr_data,
  input wire logic bus_wr,
  input wire logic bus_rd,
  output logic [7:0] bus_rd_data,
  output logic internal_reset,
  output logic clock_generator_enable,
  output logic clock_generator_output,
  output logic bus_clk,
  output logic cpu_clk,
  output logic periph_clk,
  output logic [15:0] reset_vector_addr,
  output logic watchdog_disabled
);
  srs_pkg::srs_state_e state_q;
  srs_pkg::srs_state_e state_d;
  logic [srs_pkg::SY_W-1:0] async_in;
  logic [srs_pkg::SY_W-1:0] sync1_q;
  logic [srs_pkg::SY_W-1:0] sync2_q;
  logic [srs_pkg::CNT_W-1:0] cnt_q;
  logic [srs_pkg::CNT_W-1:0] cnt_d;
  logic [srs_pkg::CNT_W-1:0] stop_rec_last;
  logic [srs_pkg::PIN_CNT_W-1:0] pin_cnt_q;
  logic [7:0] cause_q;
  logic [7:0] ev;
  logic [srs_pkg::CFG_W-1:0] config_q;
  logic [7:0] rd_data_q;
  logic internal_reset_q;
  logic cge_q;
  logic gen_q;
  logic bus_q;
  logic bus_d;
  logic cpu_clk_q;
  logic periph_clk_q;
  logic pin_low;
  logic pin_ev;
  logic long_ev;
  logic short_ev;
  logic running;
  logic cnt_clr;
  logic service_wr;
  logic wdog_tick;
  logic cpu_on;
  logic periph_on;
  logic wd_disable;

  srs_wdog_if wd_if ();

  // every external reset, test-pin and watchdog source crosses two flops before use; monitor_mode, wake_irq and the cpu status inputs are used directly
  assign async_in[srs_pkg::SY_POR] = power_on_pulse;
  assign async_in[srs_pkg::SY_LVI] = low_voltage_detect;
  assign async_in[srs_pkg::SY_PIN] = ext_reset_n;
  assign async_in[srs_pkg::SY_TST] = test_high_voltage;
  assign async_in[srs_pkg::SY_MEN] = blank_vector_monitor_reset;
  assign async_in[srs_pkg::SY_WDOG] = wd_if.overflow;

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      sync1_q <= srs_pkg::SY_RESET;
      sync2_q <= srs_pkg::SY_RESET;
    end
    else
    begin
      sync1_q <= async_in;
      sync2_q <= sync1_q;
    end
  end

  assign running = (state_q == srs_pkg::ST_RUN);
  assign pin_low = !sync2_q[srs_pkg::SY_PIN];
  // pin flag is set once, when the low level has lasted the minimum time
  assign pin_ev = pin_low && (pin_cnt_q == srs_pkg::PIN_LOW_LAST);

  // noise on the test pin alone cannot disable the watchdog
  assign wd_disable = sync2_q[srs_pkg::SY_TST] && monitor_mode;
  assign watchdog_disabled = wd_disable;

  always_comb
  begin
    ev = srs_pkg::DATA_ZERO;
    ev[srs_pkg::CB_POR] = sync2_q[srs_pkg::SY_POR];
    ev[srs_pkg::CB_LVI] = sync2_q[srs_pkg::SY_LVI];
    ev[srs_pkg::CB_PIN] = pin_ev;
    ev[srs_pkg::CB_WDOG] = sync2_q[srs_pkg::SY_WDOG]
      && (running || state_q == srs_pkg::ST_WAIT);
    ev[srs_pkg::CB_MEN] = sync2_q[srs_pkg::SY_MEN] && running;
    ev[srs_pkg::CB_ILLEGAL_OPCODE_FLAG] = running && (cpu_illegal_op
      || (cpu_stop_exec && !config_q[srs_pkg::CFG_STOP_EN]));
    ev[srs_pkg::CB_ILLEGAL_ADDRESS_FLAG] = running && cpu_opcode_fetch && cpu_addr_unmapped;
  end

  assign long_ev = ev[srs_pkg::CB_POR] || ev[srs_pkg::CB_LVI];
  assign short_ev = ev[srs_pkg::CB_WDOG] || ev[srs_pkg::CB_MEN] || ev[srs_pkg::CB_ILLEGAL_OPCODE_FLAG]
                    || ev[srs_pkg::CB_ILLEGAL_ADDRESS_FLAG];

  assign stop_rec_last = config_q[srs_pkg::CFG_SHORT_STOP_RECOVERY] ? srs_pkg::STOP_REC_SHORT_LAST
                                                      : srs_pkg::STOP_REC_LONG_LAST;

  always_comb
  begin
    state_d = state_q;
    if (long_ev)
    begin
      state_d = srs_pkg::ST_STAB;
    end
    else if (pin_low && state_q != srs_pkg::ST_STAB)
    begin
      state_d = srs_pkg::ST_PIN;
    end
    else if (short_ev && state_q != srs_pkg::ST_STAB)
    begin
      state_d = srs_pkg::ST_VEC;
    end
    else
    begin
      case (state_q)
        srs_pkg::ST_STAB:
        begin
          if (cnt_q == srs_pkg::STAB_LAST)
          begin
            state_d = srs_pkg::ST_VEC;
          end
        end
        srs_pkg::ST_VEC:
        begin
          if (cnt_q == srs_pkg::VEC_LAST)
          begin
            state_d = srs_pkg::ST_RUN;
          end
        end
        srs_pkg::ST_PIN:
        begin
          state_d = srs_pkg::ST_VEC;
        end
        srs_pkg::ST_RUN:
        begin
          if (cpu_stop_exec && config_q[srs_pkg::CFG_STOP_EN])
          begin
            state_d = srs_pkg::ST_STOP;
          end
          else if (cpu_wait_exec)
          begin
            state_d = srs_pkg::ST_WAIT;
          end
        end
        srs_pkg::ST_WAIT:
        begin
          if (wake_irq)
          begin
            state_d = srs_pkg::ST_RUN;
          end
        end
        srs_pkg::ST_STOP:
        begin
          if (wake_irq)
          begin
            state_d = srs_pkg::ST_STOP_REC;
          end
        end
        srs_pkg::ST_STOP_REC:
        begin
          if (cnt_q == stop_rec_last)
          begin
            state_d = srs_pkg::ST_RUN;
          end
        end
        default:
        begin
          state_d = srs_pkg::ST_STAB;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      state_q <= srs_pkg::ST_STAB;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  // a held low-voltage level keeps clearing, so recovery starts on its release
  assign cnt_clr = long_ev
                   || ((state_d != state_q) && (state_d == srs_pkg::ST_STAB
                   || state_d == srs_pkg::ST_VEC || state_d == srs_pkg::ST_STOP
                   || state_d == srs_pkg::ST_STOP_REC));

  assign service_wr = bus_wr && (bus_addr == srs_pkg::ADDR_SERVICE) && !internal_reset_q;

  always_comb
  begin
    if (cnt_clr)
    begin
      cnt_d = srs_pkg::CNT_ZERO;
    end
    else if (state_q == srs_pkg::ST_STOP)
    begin
      cnt_d = cnt_q;
    end
    else if (service_wr)
    begin
      cnt_d = cnt_q & srs_pkg::SERVICE_KEEP;
    end
    else
    begin
      cnt_d = cnt_q + srs_pkg::CNT_ONE;
    end
  end

  // counter steps on ref_clk rising edge; one edge per source cycle either way
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      cnt_q <= srs_pkg::CNT_ZERO;
    end
    else
    begin
      cnt_q <= cnt_d;
    end
  end

  assign wdog_tick = (cnt_q == srs_pkg::CNT_FULL) && !cnt_clr && !service_wr
                     && (running || state_q == srs_pkg::ST_WAIT);

  assign wd_if.tick = wdog_tick;
  assign wd_if.service = service_wr;
  assign wd_if.disable_wd = wd_disable;
  assign wd_if.clear = internal_reset_q;

  srs_wdog u_wdog (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .wd(wd_if.wdog)
  );

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      pin_cnt_q <= '0;
    end
    else if (!pin_low)
    begin
      pin_cnt_q <= '0;
    end
    else if (pin_cnt_q <= srs_pkg::PIN_LOW_LAST)
    begin
      pin_cnt_q <= pin_cnt_q + 1'b1;
    end
    else
    begin
      // parked one past the last count so a long low cannot wrap and fire again
      pin_cnt_q <= pin_cnt_q;
    end
  end

  // power-on wipes older causes; simultaneous causes all stay set
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      cause_q <= srs_pkg::CAUSE_RESET;
    end
    else if (ev[srs_pkg::CB_POR])
    begin
      cause_q <= ev;
    end
    else
    begin
      cause_q <= cause_q | ev;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n || internal_reset_q)
    begin
      config_q <= srs_pkg::CFG_RESET;
    end
    else if (bus_wr && bus_addr == srs_pkg::ADDR_CONFIG)
    begin
      config_q <= bus_wr_data[srs_pkg::CFG_W-1:0];
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      rd_data_q <= srs_pkg::DATA_ZERO;
    end
    else if (bus_rd && bus_addr == srs_pkg::ADDR_CAUSE)
    begin
      rd_data_q <= cause_q;
    end
    else if (bus_rd && bus_addr == srs_pkg::ADDR_CONFIG)
    begin
      rd_data_q <= {6'h00, config_q};
    end
    else
    begin
      rd_data_q <= srs_pkg::DATA_ZERO;
    end
  end

  assign bus_rd_data = rd_data_q;

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      internal_reset_q <= 1'b1;
    end
    else
    begin
      internal_reset_q <= (state_d == srs_pkg::ST_STAB) || (state_d == srs_pkg::ST_VEC)
                || (state_d == srs_pkg::ST_PIN);
    end
  end

  assign internal_reset = internal_reset_q;
  assign reset_vector_addr = monitor_mode ? srs_pkg::VEC_MONITOR : srs_pkg::VEC_USER;

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      cge_q <= 1'b0;
    end
    else
    begin
      cge_q <= 1'b1;
    end
  end

  assign clock_generator_enable = cge_q;

  // generator output is ref_clk halved, bus clock halves it again
  assign bus_d = bus_q ^ gen_q;

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      gen_q <= 1'b0;
      bus_q <= 1'b0;
    end
    else
    begin
      gen_q <= !gen_q && cge_q;
      bus_q <= bus_d;
    end
  end

  assign cpu_on = (state_d == srs_pkg::ST_RUN) || (state_d == srs_pkg::ST_VEC);
  assign periph_on = cpu_on || (state_d == srs_pkg::ST_WAIT);

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      cpu_clk_q <= 1'b0;
      periph_clk_q <= 1'b0;
    end
    else
    begin
      cpu_clk_q <= bus_d && cpu_on;
      periph_clk_q <= bus_d && periph_on;
    end
  end

  assign clock_generator_output = gen_q;
  assign bus_clk = bus_q;
  assign cpu_clk = cpu_clk_q;
  assign periph_clk = periph_clk_q;
endmodule : srs_top
`default_nettype wire

// [srs_top_sva.sv]
`timescale 1ns/1ps
`default_nettype none
module srs_top_sva (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic monitor_mode,
  input wire logic cpu_illegal_op,
  input wire logic cpu_opcode_fetch,
  input wire logic cpu_addr_unmapped,
  input wire logic bus_rd,
  input wire logic [7:0] bus_rd_data,
  input wire logic internal_reset,
  input wire logic clock_generator_enable,
  input wire logic bus_clk,
  input wire logic cpu_clk,
  input wire logic periph_clk,
  input wire logic [15:0] reset_vector_addr,
  input wire logic watchdog_disabled
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);
  // cycles since release, frozen once the first recovery ends
  logic first_q;
  logic [12:0] cnt_q;
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      first_q <= 1'b1;
    else if (!internal_reset)
      first_q <= 1'b0;
  end
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      cnt_q <= 13'h0000;
    else if (first_q && cnt_q != 13'h1fff)
      cnt_q <= cnt_q + 13'h0001;
  end
  sequence s_bus_half;
    bus_clk ##1 !bus_clk;
  endsequence
  sequence s_illegal_opcode_flag_seen;
    cpu_illegal_op && !internal_reset;
  endsequence
  sequence s_illegal_address_flag_seen;
    cpu_opcode_fetch && cpu_addr_unmapped && !internal_reset;
  endsequence
  chk_bus_half: assert property ($rose(bus_clk) |=> s_bus_half)
    else $error("bus clock not a quarter of the source");
  // the divider itself runs free; only the gated copies wait for the count
  chk_stab_off: assert property ((first_q && cnt_q < 13'h0fa0)
    |-> internal_reset && !cpu_clk && !periph_clk)
    else $error("clocks running during stabilization");
  chk_por_len: assert property (($fell(internal_reset) && first_q)
    |-> cnt_q >= 13'h103b && cnt_q <= 13'h1050)
    else $error("power-on recovery length wrong");
  chk_clk_gated: assert property ((cpu_clk || periph_clk) |-> bus_clk)
    else $error("gated clock out of phase with bus clock");
  chk_vec_sel: assert property (reset_vector_addr
    == (monitor_mode ? srs_pkg::VEC_MONITOR : srs_pkg::VEC_USER))
    else $error("reset vector address wrong");
  chk_illegal_opcode_flag_rst: assert property (s_illegal_opcode_flag_seen |=> internal_reset)
    else $error("illegal opcode did not reset");
  chk_illegal_address_flag_rst: assert property (s_illegal_address_flag_seen |=> internal_reset)
    else $error("unmapped opcode fetch did not reset");
  chk_gen_on: assert property ($rose(rst_n) |=> clock_generator_enable)
    else $error("clock generator not enabled after power-on");
  chk_rd_idle: assert property (!$past(bus_rd) |-> bus_rd_data == 8'h00)
    else $error("read data outside its cycle");
  chk_wd_dis: assert property (watchdog_disabled |-> monitor_mode)
    else $error("watchdog disabled outside monitor mode");
endmodule : srs_top_sva
`default_nettype wire

// [srs_cpu_model.sv]
`timescale 1ns/1ps
`default_nettype none
// cpu side: turns a bench command into one-cycle status pulses
module srs_cpu_model (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [2:0] cmd,
  output logic cpu_illegal_op,
  output logic cpu_opcode_fetch,
  output logic cpu_addr_unmapped,
  output logic cpu_stop_exec,
  output logic cpu_wait_exec
);
  initial
  begin
    {cpu_illegal_op, cpu_opcode_fetch, cpu_addr_unmapped, cpu_stop_exec, cpu_wait_exec} = 5'h00;
  end
  always @(posedge ref_clk)
  begin
    cpu_illegal_op <= rst_n && cmd == 3'h1;
    cpu_opcode_fetch <= rst_n && cmd == 3'h2;
    cpu_addr_unmapped <= rst_n && (cmd == 3'h2 || cmd == 3'h3);
    cpu_stop_exec <= rst_n && cmd == 3'h4;
    cpu_wait_exec <= rst_n && cmd == 3'h5;
  end
endmodule : srs_cpu_model
`default_nettype wire

// [system_reset_clock_sequencer_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module system_reset_clock_sequencer_tb;
  logic ref_clk, rst_n, power_on_pulse, low_voltage_detect, ext_reset_n, test_high_voltage;
  logic blank_vector_monitor_reset, monitor_mode, wake_irq, bus_wr, bus_rd;
  logic cpu_illegal_op, cpu_opcode_fetch, cpu_addr_unmapped, cpu_stop_exec, cpu_wait_exec;
  logic internal_reset, clock_generator_enable, clock_generator_output, bus_clk, cpu_clk;
  logic periph_clk, watchdog_disabled, ca, pa;
  logic [15:0] bus_addr, reset_vector_addr;
  logic [7:0] bus_wr_data, bus_rd_data, rd;
  logic [2:0] cmd;
  logic [1:0] bq[$];
  integer n_fail, samples_checked, seed, exp_cause, n, i;
  srs_cpu_model srs_cpu_model_inst (.ref_clk, .rst_n, .cmd, .cpu_illegal_op, .cpu_opcode_fetch,
    .cpu_addr_unmapped, .cpu_stop_exec, .cpu_wait_exec);
  srs_top srs_top_inst (.ref_clk, .rst_n, .power_on_pulse, .low_voltage_detect, .ext_reset_n,
    .test_high_voltage, .blank_vector_monitor_reset, .monitor_mode, .cpu_illegal_op,
    .cpu_opcode_fetch, .cpu_addr_unmapped, .cpu_stop_exec, .cpu_wait_exec, .wake_irq, .bus_addr,
    .bus_wr_data, .bus_wr, .bus_rd, .bus_rd_data, .internal_reset, .clock_generator_enable,
    .clock_generator_output, .bus_clk, .cpu_clk, .periph_clk, .reset_vector_addr,
    .watchdog_disabled);
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked = samples_checked + 1;
    if (seen !== exp)
    begin
      n_fail = n_fail + 1;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : finish_test
  task automatic bus_write(input logic [15:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    bus_wr <= 1'b1;
    bus_addr <= a;
    bus_wr_data <= d;
    @(posedge ref_clk);
    bus_wr <= 1'b0;
  endtask : bus_write
  task automatic bus_read(input logic [15:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    bus_rd <= 1'b1;
    bus_addr <= a;
    @(posedge ref_clk);
    bus_rd <= 1'b0;
    #1;
    d = bus_rd_data;
  endtask : bus_read
  task automatic cause_chk;
    bus_read(srs_pkg::ADDR_CAUSE, rd);
    check(rd, exp_cause[7:0]);
  endtask : cause_chk
  task automatic pulse_cmd(input logic [2:0] c);
    @(posedge ref_clk);
    cmd <= c;
    @(posedge ref_clk);
    cmd <= 3'h0;
  endtask : pulse_cmd
  // bounded wait; running out counts as a mismatch
  task automatic wait_rst(input logic v, input integer lim, output integer c);
    c = 0;
    while (internal_reset !== v && c < lim)
    begin
      @(posedge ref_clk);
      #1;
      c = c + 1;
    end
    check(c < lim, 1'b1);
  endtask : wait_rst
  task automatic wait_cpu(input integer lim, output integer c);
    c = 0;
    while (cpu_clk !== 1'b1 && c < lim)
    begin
      @(posedge ref_clk);
      #1;
      c = c + 1;
    end
  endtask : wait_cpu
  task automatic rst_len(input integer lo, input integer hi);
    integer c;
    wait_rst(1'b1, 12, c);
    wait_rst(1'b0, 5000, c);
    check(c >= lo && c <= hi, 1'b1);
  endtask : rst_len
  initial
  begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  initial
  begin
    repeat (40000) @(posedge ref_clk);
    n_fail = n_fail + 1;
    finish_test();
  end
  initial
  begin
    n_fail = 0;
    samples_checked = 0;
    seed = 53211;
    {rst_n, power_on_pulse, low_voltage_detect, test_high_voltage, wake_irq} = 5'h00;
    {blank_vector_monitor_reset, monitor_mode, bus_wr, bus_rd, cmd} = 7'h00;
    ext_reset_n = 1'b1;
    bus_addr = 16'h0000;
    bus_wr_data = 8'h00;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    exp_cause = 8'h80;
    wait_rst(1'b0, 5000, n);
    check(n >= 4160 && n <= 4170, 1'b1);
    check(clock_generator_enable, 1'b1);
    cause_chk();
    // software services the watchdog as soon as reset is over
    bus_write(srs_pkg::ADDR_SERVICE, 8'($random(seed)));
    bus_read({8'h20, 8'($random(seed))}, rd);
    check(rd, 8'h00);
    check(reset_vector_addr, srs_pkg::VEC_USER);
    @(posedge ref_clk);
    monitor_mode <= 1'b1;
    test_high_voltage <= 1'b1;
    repeat (4) @(posedge ref_clk);
    #1;
    check(reset_vector_addr, srs_pkg::VEC_MONITOR);
    check(watchdog_disabled, 1'b1);
    @(posedge ref_clk);
    monitor_mode <= 1'b0;
    test_high_voltage <= 1'b0;
    for (i = 0; i < 8; i++)
    begin
      @(posedge ref_clk);
      #1;
      bq.push_back({bus_clk, clock_generator_output});
    end
    check(watchdog_disabled, 1'b0);
    for (i = 0; i < 4; i++)
    begin
      check(bq[i][1] ^ bq[i+2][1], 1'b1);
      check(bq[i][0] ^ bq[i+1][0], 1'b1);
    end
    $display("power-on and clocks done");
    pulse_cmd(3'h1);
    rst_len(64, 70);
    exp_cause = exp_cause | 8'h10;
    cause_chk();
    pulse_cmd(3'h4);
    rst_len(64, 70);
    cause_chk();
    // long then short stop recovery
    for (i = 0; i < 2; i++)
    begin
      bus_write(srs_pkg::ADDR_CONFIG, (i == 1) ? 8'h03 : 8'h01);
      pulse_cmd(3'h4);
      repeat (20) @(posedge ref_clk);
      #1;
      check(cpu_clk | periph_clk, 1'b0);
      @(posedge ref_clk);
      wake_irq <= 1'b1;
      @(posedge ref_clk);
      wake_irq <= 1'b0;
      wait_cpu(5000, n);
      check(n >= ((i == 1) ? 32 : 4096) && n <= ((i == 1) ? 48 : 4112), 1'b1);
    end
    $display("stop done");
    pulse_cmd(3'h5);
    {ca, pa} = 2'h0;
    repeat (2) @(posedge ref_clk);
    for (i = 0; i < 8; i++)
    begin
      @(posedge ref_clk);
      #1;
      ca = ca | cpu_clk;
      pa = pa | periph_clk;
    end
    check({ca, pa}, 2'h1);
    @(posedge ref_clk);
    wake_irq <= 1'b1;
    @(posedge ref_clk);
    wake_irq <= 1'b0;
    wait_cpu(20, n);
    check(cpu_clk, 1'b1);
    bus_write(srs_pkg::ADDR_SERVICE, 8'($random(seed)));
    pulse_cmd(3'h3);
    repeat (6) @(posedge ref_clk);
    #1;
    check(internal_reset, 1'b0);
    pulse_cmd(3'h2);
    rst_len(64, 70);
    exp_cause = exp_cause | 8'h08;
    cause_chk();
    $display("wait and address done");
    for (i = 0; i < 2; i++)
    begin
      @(posedge ref_clk);
      ext_reset_n <= 1'b0;
      repeat ((i == 1) ? 30 : 5) @(posedge ref_clk);
      ext_reset_n <= 1'b1;
      rst_len(60, 75);
      exp_cause = exp_cause | ((i == 1) ? 8'h40 : 8'h00);
      cause_chk();
    end
    @(posedge ref_clk);
    low_voltage_detect <= 1'b1;
    blank_vector_monitor_reset <= 1'b1;
    repeat (4) @(posedge ref_clk);
    low_voltage_detect <= 1'b0;
    blank_vector_monitor_reset <= 1'b0;
    rst_len(4155, 4175);
    exp_cause = exp_cause | 8'h06;
    cause_chk();
    $display("pin and low voltage done");
    // a power-on pulse in mid-run wipes every older cause
    @(posedge ref_clk);
    power_on_pulse <= 1'b1;
    repeat (4) @(posedge ref_clk);
    power_on_pulse <= 1'b0;
    rst_len(4155, 4175);
    exp_cause = 8'h80;
    cause_chk();
    $display("power-on pulse done");
    finish_test();
  end
endmodule : system_reset_clock_sequencer_tb
bind srs_top srs_top_sva srs_top_sva_inst (.ref_clk, .rst_n, .monitor_mode, .cpu_illegal_op,
  .cpu_opcode_fetch, .cpu_addr_unmapped, .bus_rd, .bus_rd_data, .internal_reset,
  .clock_generator_enable, .bus_clk, .cpu_clk, .periph_clk, .reset_vector_addr,
  .watchdog_disabled);
`default_nettype wire
